// file: hdl/lods_stop_encode.sv
// stop reason encoder
`timescale 1ns/1ps
`default_nettype none
`include "lods_defines.svh"
module lods_stop_encode
   import lods_pkg::*;
(
   input  wire lods_stop_cause_t i_cause,
   input  wire logic             i_op_err,
   input  wire logic             i_no_wm,
   input  wire logic             i_zero_ic,
   output logic                  o_report,
   output logic [7:0]            o_code
);
   wire normal = i_cause.stop_key | i_cause.step_done | i_cause.addr_match;
   wire any    = normal | i_cause.bad_first | i_cause.bad_second
               | i_cause.wm_in_io_first | i_op_err | i_no_wm | i_zero_ic;

   assign o_report = any & ~i_cause.set_ic & ~i_cause.sense_sw;
   // single table of codes, error causes before normal
   assign o_code =
      (i_cause.bad_first & i_cause.bad_second) ? `LODS_CODE_BADAB :
      i_cause.bad_second                       ? `LODS_CODE_BADB :
      i_cause.bad_first                        ? `LODS_CODE_BADA :
      i_zero_ic                                ? `LODS_CODE_ZEROIC :
      i_no_wm                                  ? `LODS_CODE_NOWM :
      i_op_err                                 ? `LODS_CODE_BADOP :
      i_cause.wm_in_io_first                   ? `LODS_CODE_WMIO :
      `LODS_CODE_NORMAL;
endmodule // lods_stop_encode
`default_nettype wire

// file: hdl/lods_top.sv
// op code recognizer and stop reporter top
`timescale 1ns/1ps
`default_nettype none
`include "lods_defines.svh"
module lods_top
   import lods_pkg::*;
(
   input  wire logic             i_clk,
   input  wire logic             i_sys_rst,
   input  wire lods_fetch_t      i_fetch,
   input  wire logic             i_tbl_wr,
   input  wire logic [7:0]       i_tbl_addr,
   input  wire logic [7:0]       i_tbl_data,
   input  wire logic             i_fetch_done,
   input  wire logic [15:0]      i_cs_addr,
   input  wire lods_stop_cause_t i_cause,
   input  wire lods_addr_t       i_addrs,
   output logic [7:0]            o_op_class,
   output logic                  o_op_valid,
   output logic                  o_op_error,
   output logic                  o_is_edit,
   output logic [2:0]            o_class_bits,
   output logic                  o_stopped,
   output logic [7:0]            o_storage_data_display_register,
   output logic [15:0]           o_instr_addr_lights,
   output logic [15:0]           o_storage_address_lights_pair,
   output logic [15:0]           o_aux_address_register_pair
);
   // ==========================================
   // decode
   // ==========================================
   lods_state_t state;
   lods_state_t next_state;
   logic [7:0]  tbl_rd;
   logic        explicit_bad;
   logic        no_wm_seen;
   logic        zero_ic_seen;
   logic        start_fetch;

   function automatic logic is_collider(input logic [7:0] ch);
      return (ch == `LODS_CHAR_BLANK) || (ch == `LODS_CHAR_MINUS)
          || (ch == `LODS_CHAR_SIX);
   endfunction

   wire [7:0] forced_char = i_fetch.op_char | `LODS_FORCE_MASK;
   wire       collide     = is_collider(i_fetch.op_char);
   wire       tbl_err     = (tbl_rd == `LODS_TBL_INVALID) | explicit_bad;
   wire       at_stop     = (i_cs_addr == `LODS_STOP_ADDR);
   wire       zero_fetch  = (i_fetch.fetch_addr == `LODS_ZERO_ADDR);
   wire       stop_rep;
   wire [7:0] stop_code;

   assign start_fetch = (state == LODS_IDLE) & i_fetch.valid;

   lods_xlate_table u_table (
      .i_clk     (i_clk),
      .i_wr_en   (i_tbl_wr),
      .i_wr_addr (i_tbl_addr),
      .i_wr_data (i_tbl_data),
      .i_rd_addr (forced_char),
      .o_rd_data (tbl_rd)
   );

   lods_stop_encode u_enc (
      .i_cause   (i_cause),
      .i_op_err  (o_op_error),
      .i_no_wm   (no_wm_seen),
      .i_zero_ic (zero_ic_seen),
      .o_report  (stop_rep),
      .o_code    (stop_code)
   );

   // ==========================================
   // fetch sequence
   // ==========================================
   always_comb begin
      next_state = state;
      case (state)
         LODS_IDLE: begin
            if (i_fetch.valid) begin
               if (zero_fetch | ~i_fetch.word_mark) begin
                  next_state = LODS_ERR;
               end else begin
                  next_state = LODS_READ;
               end
            end
         end
         LODS_READ: next_state = LODS_HOLD;
         LODS_HOLD: begin
            if (i_fetch_done) begin
               next_state = LODS_IDLE;
            end
         end
         LODS_ERR:  next_state = LODS_STOP;
         LODS_STOP: begin
            if (at_stop & stop_rep) begin
               next_state = LODS_IDLE;
            end
         end
         default:   next_state = LODS_IDLE;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state        <= LODS_IDLE;
         explicit_bad <= 1'b0;
         no_wm_seen   <= 1'b0;
         zero_ic_seen <= 1'b0;
      end else begin
         state <= next_state;
         if (start_fetch) begin
            explicit_bad <= collide;
            no_wm_seen   <= ~i_fetch.word_mark;
            zero_ic_seen <= zero_fetch;
         end
      end
   end

   // ==========================================
   // class holding register
   // ==========================================
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_op_class   <= 8'h00;
         o_op_valid   <= 1'b0;
         o_op_error   <= 1'b0;
         o_is_edit    <= 1'b0;
         o_class_bits <= 3'b000;
      end else if (state == LODS_READ) begin
         o_op_class   <= tbl_rd;
         o_op_valid   <= ~tbl_err;
         o_op_error   <= tbl_err;
         o_is_edit    <= (tbl_rd == `LODS_TBL_EDIT) & ~explicit_bad;
         o_class_bits <= tbl_rd[2:0];
      end else if (state == LODS_HOLD && i_fetch_done) begin
         o_op_valid   <= 1'b0;
      end
   end

   // ==========================================
   // console stop display
   // ==========================================
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_stopped                       <= 1'b0;
         o_storage_data_display_register <= `LODS_CODE_NORMAL;
         o_instr_addr_lights             <= 16'h0000;
         o_storage_address_lights_pair   <= 16'h0000;
         o_aux_address_register_pair     <= 16'h0000;
      end else begin
         o_stopped <= at_stop & stop_rep;
         if (at_stop & stop_rep) begin
            o_storage_data_display_register <= stop_code;
            o_instr_addr_lights             <= i_addrs.instr_addr;
            o_storage_address_lights_pair   <= i_addrs.first_addr;
            o_aux_address_register_pair     <= i_addrs.second_addr;
         end
      end
   end
endmodule // lods_top
`default_nettype wire

// file: hdl/lods_xlate_table.sv
// translation table in local storage
`timescale 1ns/1ps
`default_nettype none
`include "lods_defines.svh"
module lods_xlate_table
   import lods_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_wr_en,
   input  wire logic [7:0] i_wr_addr,
   input  wire logic [7:0] i_wr_data,
   input  wire logic [7:0] i_rd_addr,
   output logic      [7:0] o_rd_data
);
   logic [7:0] table_mem [0:255];

   // loaded by the init routine; read one cycle later
   always_ff @(posedge i_clk) begin
      if (i_wr_en) begin
         table_mem[i_wr_addr] <= i_wr_data;
      end
      o_rd_data <= table_mem[i_rd_addr];
   end
endmodule // lods_xlate_table
`default_nettype wire

// file: pkg/lods_defines.svh
// constants for the op code recognizer and stop reporter
`ifndef LODS_DEFINES_SVH
`define LODS_DEFINES_SVH
`define LODS_FORCE_MASK   8'hc0
`define LODS_TBL_INVALID  8'h34
`define LODS_TBL_EDIT     8'h16
`define LODS_CHAR_EDIT_WM 8'h85
`define LODS_CHAR_BLANK   8'h40
`define LODS_CHAR_MINUS   8'h60
`define LODS_CHAR_SIX     8'hf6
`define LODS_STOP_ADDR    16'h10ff
`define LODS_ZERO_ADDR    16'h0000
`define LODS_CODE_NORMAL  8'h00
`define LODS_CODE_BADB    8'h01
`define LODS_CODE_BADA    8'h02
`define LODS_CODE_BADAB   8'h03
`define LODS_CODE_BADOP   8'h04
`define LODS_CODE_ZEROIC  8'h0c
`define LODS_CODE_NOWM    8'h11
`define LODS_CODE_WMIO    8'h14
`define LODS_CLASS_IO     2
`define LODS_CLASS_CPU    1
`define LODS_CLASS_MISC   0
`endif

// file: pkg/lods_pkg.sv
// types for the op code recognizer and stop reporter
package lods_pkg;
   typedef enum logic [2:0] {
      LODS_IDLE  = 3'b000,
      LODS_READ  = 3'b001,
      LODS_HOLD  = 3'b010,
      LODS_STOP  = 3'b011,
      LODS_ERR   = 3'b100
   } lods_state_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  op_char;
      logic        word_mark;
      logic [15:0] fetch_addr;
   } lods_fetch_t;

   typedef struct packed {
      logic [15:0] instr_addr;
      logic [15:0] first_addr;
      logic [15:0] second_addr;
   } lods_addr_t;

   typedef struct packed {
      logic stop_key;
      logic step_done;
      logic addr_match;
      logic bad_first;
      logic bad_second;
      logic wm_in_io_first;
      logic set_ic;
      logic sense_sw;
   } lods_stop_cause_t;
endpackage

// file: verification/lods_console.sv
// operator console model that reads the aux pair at a stop
`timescale 1ns/1ps
`default_nettype none
module lods_console (
   input  wire logic        i_clk,
   input  wire logic        i_stopped,
   input  wire logic [15:0] i_aux,
   output logic      [15:0] o_aux_seen
);
   // ====
   // manual display
   always_ff @(posedge i_clk) begin
      if (i_stopped) o_aux_seen <= i_aux;
   end
endmodule // lods_console
`default_nettype wire

// file: verification/lods_monitor.sv
// assertion checker for the op code recognizer and stop reporter
`timescale 1ns/1ps
`default_nettype none
module lods_monitor
   import lods_pkg::*;
(
   input wire logic             i_clk,
   input wire logic             i_sys_rst,
   input wire lods_fetch_t      i_fetch,
   input wire logic [15:0]      i_cs_addr,
   input wire lods_stop_cause_t i_cause,
   input wire lods_addr_t       i_addrs,
   input wire logic [7:0]       o_op_class,
   input wire logic             o_op_valid,
   input wire logic             o_op_error,
   input wire logic             o_is_edit,
   input wire logic [2:0]       o_class_bits,
   input wire logic             o_stopped,
   input wire logic [7:0]       o_storage_data_display_register,
   input wire logic [15:0]      o_instr_addr_lights,
   input wire logic [15:0]      o_storage_address_lights_pair,
   input wire logic [15:0]      o_aux_address_register_pair
);
   // ====
   // stop decode
   wire hit = i_cs_addr == 16'h10ff;
   wire ext = |i_cause[7:2] & ~i_cause.set_ic & ~i_cause.sense_sw;
   wire [7:0] op = i_fetch.op_char;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // ====
   // checks
   chk_class_bits: assert property (o_op_valid |-> o_class_bits == o_op_class[2:0])
      else $error("class bits");
   chk_edit_flag: assert property (o_op_valid |-> o_is_edit == (o_op_class == 8'h16))
      else $error("edit flag");
   chk_bad_entry: assert property (o_op_class == 8'h34 |-> o_op_error && !o_op_valid)
      else $error("bad entry");
   chk_collide_err: assert property (i_fetch.valid && i_fetch.word_mark && !o_op_valid
      && i_fetch.fetch_addr != 16'h0000 && op inside {8'h40, 8'h60, 8'hf6} |-> ##2 o_op_error)
      else $error("collider");
   chk_class_hold: assert property (o_op_valid && $past(o_op_valid) |-> $stable(o_op_class))
      else $error("class hold");
   chk_stop_report: assert property (hit && ext |=> o_stopped)
      else $error("stop report");
   chk_stop_lights: assert property (o_stopped |-> o_instr_addr_lights == $past(
      i_addrs.instr_addr) && o_storage_address_lights_pair == $past(i_addrs.first_addr))
      else $error("lights");
   chk_aux_kept: assert property (o_stopped |-> o_aux_address_register_pair == $past(
      i_addrs.second_addr)) else $error("aux pair");
   chk_code_both: assert property (hit && ext && i_cause.bad_first && i_cause.bad_second
      |=> o_storage_data_display_register == 8'h03) else $error("code 03");
endmodule // lods_monitor
bind lods_top lods_monitor i_lods_monitor (.i_clk, .i_sys_rst, .i_fetch, .i_cs_addr, .i_cause,
   .i_addrs, .o_op_class, .o_op_valid, .o_op_error, .o_is_edit, .o_class_bits, .o_stopped,
   .o_storage_data_display_register, .o_instr_addr_lights, .o_storage_address_lights_pair,
   .o_aux_address_register_pair);
`default_nettype wire

// file: verification/tb_legacy_opcode_decode_stop_report.sv
// self-checking bench for the op code recognizer and stop reporter
`timescale 1ns/1ps
`default_nettype none
module tb_legacy_opcode_decode_stop_report;
   import lods_pkg::*;
   logic             clk = 0, rst = 1, wr = 0, done = 0, val, err, edt, stp;
   logic [7:0]       ta = 0, td = 0, cls, disp;
   logic [15:0]      cs = 0, il, sl, al, seen;
   logic [2:0]       cb;
   lods_fetch_t      f = '0;
   lods_stop_cause_t c = '0;
   lods_addr_t       a = '{16'h0190, 16'h01f4, 16'h0258};
   logic [7:0]       k [9] = '{8'h80, 8'h40, 8'h20, 8'h08, 8'h18, 8'h10, 8'h04, 8'h82, 8'h81};
   logic [7:0]       e [9] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'h02, 8'h14, 8'h00, 8'h00};
   logic [7:0]       col [3] = '{8'h40, 8'h60, 8'hf6};
   int               bad_count = 0, checks = 0;
   always #25 clk = ~clk;
   lods_top i_lods_top (.i_clk(clk), .i_sys_rst(rst), .i_fetch(f), .i_tbl_wr(wr),
      .i_tbl_addr(ta), .i_tbl_data(td), .i_fetch_done(done), .i_cs_addr(cs), .i_cause(c),
      .i_addrs(a), .o_op_class(cls), .o_op_valid(val), .o_op_error(err), .o_is_edit(edt),
      .o_class_bits(cb), .o_stopped(stp), .o_storage_data_display_register(disp),
      .o_instr_addr_lights(il), .o_storage_address_lights_pair(sl),
      .o_aux_address_register_pair(al));
   lods_console i_lods_console (.i_clk(clk), .i_stopped(stp), .i_aux(al), .o_aux_seen(seen));
   // ====
   // shared tasks
   task chk(input logic [15:0] s, input logic [15:0] x);
      checks++;
      if (s !== x) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   task wrap_up;
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task load;
      for (int i = 0; i < 256; i++) begin
         @(negedge clk);
         wr = 1;
         ta = i[7:0];
         td = 8'h34;
         if (ta == 8'hc5) td = 8'h16;
         if (ta == 8'hc1) td = 8'h21;
         if (ta inside {8'hc0, 8'he0, 8'hf6}) td = 8'h22;
      end
      @(negedge clk);
      wr = 0;
   endtask
   task stop(input logic [15:0] at, input logic [7:0] kk, input logic [7:0] ec, input logic rep);
      logic [7:0] d0;
      logic [15:0] i0, s0;
      d0 = disp;
      i0 = il;
      s0 = sl;
      @(negedge clk);
      cs = at;
      c = kk;
      a = a + 48'h000100010001;
      @(negedge clk);
      cs = 0;
      c = '0;
      chk(stp, rep);
      chk(disp, rep ? ec : d0);
      chk(il, rep ? a.instr_addr : i0);
      chk(sl, rep ? a.first_addr : s0);
      @(negedge clk);
      if (rep) chk(seen, a.second_addr);
   endtask
   task fetch(input logic [7:0] ch, input logic [7:0] ec, input logic ee);
      @(negedge clk);
      f = '{1'b1, ch, 1'b1, 16'h0400};
      @(negedge clk);
      f.valid = 0;
      @(negedge clk);
      chk(err, ee);
      chk(cls, ec);
      chk(val, !ee);
      chk(edt, (ec == 8'h16) && !ee);
      chk(cb, ec[2:0]);
      @(negedge clk);
      chk(cls, ec);
      chk(val, !ee);
      done = 1;
      @(negedge clk);
      done = 0;
      chk(val, 0);
      if (ee) stop(16'h10ff, 8'h00, 8'h04, 1);
   endtask
   task fetch_bad(input logic wm, input logic [15:0] ad, input logic [7:0] ec);
      @(negedge clk);
      f = '{1'b1, 8'h85, wm, ad};
      @(negedge clk);
      f.valid = 0;
      repeat (2) @(negedge clk);
      chk(val, 0);
      stop(16'h10ff, 8'h00, ec, 1);
   endtask
   // ====
   // main sequence
   initial begin
      repeat (5) @(negedge clk);
      rst = 0;
      chk(val, 0);
      chk(stp, 0);
      chk(disp, 8'h00);
      load;
      for (int i = 0; i < 9; i++) stop(16'h10ff, k[i], e[i], k[i][1:0] == 0);
      stop(16'h1100, 8'h80, 8'h00, 0);
      fetch_bad(1, 16'h0000, 8'h0c);
      fetch_bad(0, 16'h0400, 8'h11);
      fetch(8'h85, 8'h16, 0);
      fetch(8'h05, 8'h16, 0);
      fetch(8'h01, 8'h21, 0);
      fetch(8'h99, 8'h34, 1);
      foreach (col[i]) fetch(col[i], 8'h22, 1);
      wrap_up;
   end
endmodule // tb_legacy_opcode_decode_stop_report
`default_nettype wire
